// *** sequencer_status_readback.sv ***
// Read-only status register bank of the power sequencer
`timescale 1ns/1ns
`default_nettype none
`include "seq_status_params.svh"
module sequencer_status_readback
  import seq_status_pkg::*;
#(
  parameter int ENABLE_PINS = 12
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Register port from the serial management front end
  input wire logic [7:0] regAddr,
  input wire logic regRead,
  input wire logic regWrite,
  input wire logic [7:0] regWriteData,
  output logic [7:0] regReadData,
  // Pins (asynchronous to clock)
  input wire logic irqOutN,
  input wire logic resetOutN,
  input wire logic sleepInputN,
  input wire logic activeShutdownInput,
  input wire logic [ENABLE_PINS-1:0] enableSense,
  // Internal state from the sequencer, same clock
  input wire seq_status_pkg::sequencer_mode_type sequencerMode,
  input wire logic [ENABLE_PINS-1:0] enableDrive,
  input wire logic watchdogOpen,
  input wire logic watchdogEarlyEvent,
  input wire logic watchdogExpiredEvent,
  input wire seq_status_pkg::self_test_type selfTest,
  input wire logic resetEvent,
  input wire seq_status_pkg::reset_event_type resetCause
);
  import seq_status_pkg::*;

  typedef struct packed {
    logic [7:0] readData;
    logic watchdogEarly;
    logic watchdogExpired;
    logic [7:0] lastCause;
  } state_type;

  logic rstMeta;
  logic rstN;
  logic [3:0] pinsSync;
  logic [ENABLE_PINS-1:0] senseSync;
  state_type state;
  state_type next_state;
  logic [7:0] controlValue;
  logic [7:0] watchdogValue;
  logic [7:0] selfTestValue;
  logic [7:0] causeValue;
  logic [15:0] driveWord;
  logic [15:0] senseWord;

  // Reset release through two flops
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta <= 1'b0;
      rstN <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstN <= rstMeta;
    end
  end

  pin_sync #(.WIDTH(4)) controlSync (
    .clock(clock),
    .rstN(rstN),
    .pinIn({irqOutN, resetOutN, sleepInputN, activeShutdownInput}),
    .pinOut(pinsSync)
  );

  pin_sync #(.WIDTH(ENABLE_PINS)) senseSyncInst (
    .clock(clock),
    .rstN(rstN),
    .pinIn(enableSense),
    .pinOut(senseSync)
  );

  function automatic logic [1:0] seq_code(input sequencer_mode_type mode);
    case (mode)
      SeqSleep: seq_code = `SEQ_CODE_SLEEP;
      SeqActive: seq_code = `SEQ_CODE_ACTIVE;
      default: seq_code = `SEQ_CODE_SHUTDOWN;
    endcase
  endfunction

  // Pins 12..9 land in the upper byte low nibble, 8..1 in the lower byte
  always_comb begin
    driveWord = 16'h0000;
    senseWord = 16'h0000;
    driveWord[ENABLE_PINS-1:0] = enableDrive;
    senseWord[ENABLE_PINS-1:0] = senseSync;
  end

  always_comb begin
    controlValue = `STATUS_RESET_VALUE;
    controlValue[`BIT_IRQ_OUT_STATE] = pinsSync[3];
    controlValue[`BIT_RESET_OUT_STATE] = pinsSync[2];
    controlValue[`BIT_SLEEP_INPUT_STATE] = pinsSync[1];
    controlValue[`BIT_ACTIVE_INPUT_STATE] = pinsSync[0];
    controlValue[1:0] = seq_code(sequencerMode);
    watchdogValue = `STATUS_RESET_VALUE;
    watchdogValue[`BIT_WD_OPEN] = watchdogOpen;
    watchdogValue[`BIT_WD_EARLY] = state.watchdogEarly;
    watchdogValue[`BIT_WD_EXPIRED] = state.watchdogExpired;
    selfTestValue = `STATUS_RESET_VALUE;
    selfTestValue[`BIT_SELF_TEST_DONE] = selfTest.bistDone;
    selfTestValue[`BIT_SINGLE_ERROR_CORRECTED] = selfTest.eccCorrected;
    selfTestValue[3:0] = selfTest.bistFail;
    // Emergency flag goes into bit 4 here; an event with only that flag set is not stored
    causeValue = `STATUS_RESET_VALUE;
    causeValue[`BIT_EXT_RESET] = resetCause.externalReset;
    causeValue[`BIT_WD_RESET] = resetCause.watchdogReset;
    causeValue[`BIT_EMERGENCY] = resetCause.emergency;
    causeValue[`BIT_ACTIVE_LOW] = resetCause.activeLow;
    causeValue[`BIT_WD_SHUTDOWN] = resetCause.watchdogShutdown;
    if (resetCause.watchdogShutdown) begin
      causeValue[1:0] = resetCause.powerdownMode;
    end else begin
      causeValue[1:0] = resetCause.forcedCode;
    end
  end

  always_comb begin
    next_state = state;
    if (regRead) begin
      case (regAddr)
        `ADDR_CONTROL_PIN_STATE: next_state.readData = controlValue;
        `ADDR_ENABLE_DRIVE_UPPER: next_state.readData = {4'h0, driveWord[11:8]};
        `ADDR_ENABLE_DRIVE_LOWER: next_state.readData = driveWord[7:0];
        `ADDR_ENABLE_SENSE_UPPER: next_state.readData = {4'h0, senseWord[11:8]};
        `ADDR_ENABLE_SENSE_LOWER: next_state.readData = senseWord[7:0];
        `ADDR_WATCHDOG_STATE: next_state.readData = watchdogValue;
        `ADDR_SELF_TEST_STATE: next_state.readData = selfTestValue;
        `ADDR_LAST_RESET_CAUSE: next_state.readData = state.lastCause;
        default: next_state.readData = `STATUS_RESET_VALUE;
      endcase
    end
    // Clear on read, but an event in the same cycle wins so it is not lost
    if (regRead && regAddr == `ADDR_WATCHDOG_STATE) begin
      next_state.watchdogEarly = 1'b0;
      next_state.watchdogExpired = 1'b0;
    end
    if (watchdogEarlyEvent) begin
      next_state.watchdogEarly = 1'b1;
    end
    if (watchdogExpiredEvent) begin
      next_state.watchdogExpired = 1'b1;
    end
    // An event carrying only the emergency flag leaves the old cause in place
    if (resetEvent && !(resetCause.emergency && causeValue == 8'h10)) begin
      next_state.lastCause = causeValue;
    end
    // Writes have no path into any field
  end

  // Cause is cleared with the rest of the state whenever rstN is low
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign regReadData = state.readData;

endmodule
`default_nettype wire

// *** seq_status_params.svh ***
// Offsets, field positions, reset value and sequencer codes for the sequencer status bank
`ifndef SEQ_STATUS_PARAMS_SVH
`define SEQ_STATUS_PARAMS_SVH

`define ADDR_CONTROL_PIN_STATE 8'h13
`define ADDR_ENABLE_DRIVE_UPPER 8'h14
`define ADDR_ENABLE_DRIVE_LOWER 8'h15
`define ADDR_ENABLE_SENSE_UPPER 8'h16
`define ADDR_ENABLE_SENSE_LOWER 8'h17
`define ADDR_WATCHDOG_STATE 8'h18
`define ADDR_SELF_TEST_STATE 8'h19
`define ADDR_LAST_RESET_CAUSE 8'h1a
`define STATUS_RESET_VALUE 8'h00
`define BIT_IRQ_OUT_STATE 5
`define BIT_RESET_OUT_STATE 4
`define BIT_SLEEP_INPUT_STATE 3
`define BIT_ACTIVE_INPUT_STATE 2
`define BIT_WD_OPEN 3
`define BIT_WD_EARLY 1
`define BIT_WD_EXPIRED 0
`define BIT_SELF_TEST_DONE 6
`define BIT_SINGLE_ERROR_CORRECTED 5
`define BIT_EXT_RESET 7
`define BIT_WD_RESET 6
`define BIT_EMERGENCY 4
`define BIT_ACTIVE_LOW 3
`define BIT_WD_SHUTDOWN 2
`define SEQ_CODE_SHUTDOWN 2'h0
`define SEQ_CODE_SLEEP 2'h1
`define SEQ_CODE_ACTIVE 2'h3

`endif

// *** seq_status_pkg.sv ***
// Types shared by the sequencer status bank
package seq_status_pkg;
  typedef enum logic [1:0] {SeqShutdown, SeqSleep, SeqActive} sequencer_mode_type;
  typedef struct packed {
    logic externalReset;
    logic watchdogReset;
    logic emergency;
    logic activeLow;
    logic watchdogShutdown;
    logic [1:0] forcedCode;
    logic [1:0] powerdownMode;
  } reset_event_type;
  typedef struct packed {
    logic [3:0] bistFail;
    logic bistDone;
    logic eccCorrected;
  } self_test_type;
endpackage

// *** pin_sync.sv ***
// Two-flop synchroniser for a bundle of pin levels
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rstN,
  // Levels
  input wire logic [WIDTH-1:0] pinIn,
  output logic [WIDTH-1:0] pinOut
);
  logic [WIDTH-1:0] stage1;
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      stage1 <= '0;
      pinOut <= '0;
    end else begin
      stage1 <= pinIn;
      pinOut <= stage1;
    end
  end
endmodule
`default_nettype wire

// *** seq_status_chk.sv ***
// Concurrent checks on the status register bank ports
`timescale 1ns/1ns
`default_nettype none
module seq_status_chk
  import seq_status_pkg::*;
#(
  parameter int ENABLE_PINS = 12
) (
  // Clock and reset
  input wire logic clock,
  input wire logic arst_n,
  // Register port
  input wire logic [7:0] regAddr,
  input wire logic regRead,
  input wire logic [7:0] regReadData,
  // Internal state
  input wire seq_status_pkg::sequencer_mode_type sequencerMode,
  input wire logic [ENABLE_PINS-1:0] enableDrive,
  input wire logic watchdogOpen,
  input wire logic watchdogEarlyEvent,
  input wire logic watchdogExpiredEvent,
  input wire seq_status_pkg::self_test_type selfTest
);
  logic rdWd;
  logic anyEv;
  assign rdWd = regRead && regAddr == 8'h18;
  assign anyEv = watchdogEarlyEvent || watchdogExpiredEvent;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_seq_never_ten: assert property (regRead && regAddr == 8'h13 |=> regReadData[1:0] != 2'h2)
    else $error("sequencer field read as 10");
  a_seq_active_code: assert property (regRead && regAddr == 8'h13 && sequencerMode == SeqActive
    |=> regReadData[1:0] == 2'h3) else $error("active code wrong");
  a_drive_upper_map: assert property (regRead && regAddr == 8'h14
    |=> regReadData == {4'h0, $past(enableDrive[11:8])}) else $error("upper drive byte wrong");
  a_wd_early_set: assert property (watchdogEarlyEvent ##1 !rdWd ##1 rdWd |=> regReadData[1])
    else $error("early service flag missing");
  a_wd_expiry_set: assert property (watchdogExpiredEvent ##1 !rdWd ##1 rdWd |=> regReadData[0])
    else $error("expiry flag missing");
  a_wd_read_clear: assert property ((rdWd && !anyEv) ##1 (!rdWd && !anyEv)[*2] ##1 rdWd
    |=> regReadData[1:0] == 2'h0) else $error("watchdog flags not cleared by read");
  a_test_fields: assert property (regRead && regAddr == 8'h19
    |=> regReadData == {1'b0, $past(selfTest[1:0]), 1'b0, $past(selfTest[5:2])})
    else $error("self-test byte wrong");
  a_unmapped_zero: assert property (regRead && (regAddr < 8'h13 || regAddr > 8'h1a)
    |=> regReadData == 8'h00) else $error("unmapped read not zero");
endmodule
bind sequencer_status_readback seq_status_chk #(.ENABLE_PINS(ENABLE_PINS)) chk (
  .clock, .arst_n, .regAddr, .regRead, .regReadData, .sequencerMode,
  .enableDrive, .watchdogOpen, .watchdogEarlyEvent, .watchdogExpiredEvent, .selfTest
);
`default_nettype wire

// *** host_model.sv ***
// Host side of the register port: one read or write cycle per call
`timescale 1ns/1ns
`default_nettype none
module host_model (
  // Clock
  input wire logic clock,
  // Register port
  output logic [7:0] regAddr,
  output logic regRead,
  output logic regWrite,
  output logic [7:0] regWriteData,
  input wire logic [7:0] regReadData
);
  initial begin
    regAddr = 8'h00;
    regRead = 1'b0;
    regWrite = 1'b0;
    regWriteData = 8'h00;
  end
  // Data is registered at the taking edge, so it is picked up one edge later
  task automatic readReg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    @(posedge clock);
    #1 d = regReadData;
  endtask
  task automatic writeReg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    regAddr <= a;
    regWriteData <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask
endmodule
`default_nettype wire

// *** sequencer_status_readback_tb_top.sv ***
// Self-checking bench for the status register bank
`timescale 1ns/1ns
`default_nettype none
`define CHECK_EQ(g, e) begin checksDone++; if ((g) !== (e)) begin failCount++; \
  $display("unexpected t=%0t got=%h exp=%h", $time, g, e); end end
module sequencer_status_readback_tb_top;
  import seq_status_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] regAddr, regWriteData, regReadData, got;
  logic regRead, regWrite;
  logic irqOutN = 1'b0, resetOutN = 1'b0, sleepInputN = 1'b0, activeShutdownInput = 1'b0;
  logic [11:0] enableSense = 12'h000, enableDrive = 12'h000;
  sequencer_mode_type sequencerMode = SeqShutdown;
  logic watchdogOpen = 1'b0, watchdogEarlyEvent = 1'b0, watchdogExpiredEvent = 1'b0;
  logic resetEvent = 1'b0;
  self_test_type selfTest = '0;
  reset_event_type resetCause = '0;
  int failCount = 0;
  int checksDone = 0;
  // Cause vector in the upper nine bits, expected byte in the lower eight
  logic [16:0] causeTable [5] = '{
    17'h10882,
    17'h04082,
    17'h09747,
    17'h06018,
    17'h02c0b};
  always #5 clock = ~clock;
  host_model host (.clock, .regAddr, .regRead, .regWrite, .regWriteData, .regReadData);
  sequencer_status_readback dut (.clock, .arst_n, .regAddr, .regRead, .regWrite,
    .regWriteData, .regReadData, .irqOutN, .resetOutN, .sleepInputN, .activeShutdownInput,
    .enableSense, .sequencerMode, .enableDrive, .watchdogOpen, .watchdogEarlyEvent,
    .watchdogExpiredEvent, .selfTest, .resetEvent, .resetCause);
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    host.readReg(a, got);
    `CHECK_EQ(got, e)
  endtask
  task automatic endSim();
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    repeat (3) @(posedge clock);
    for (int a = 8'h12; a <= 8'h1b; a++) begin
      rd(8'(a), 8'h00);
    end
    $display("reset values done");
    @(posedge clock);
    {irqOutN, resetOutN, sleepInputN, activeShutdownInput} <= 4'ha;
    sequencerMode <= SeqActive;
    repeat (3) @(posedge clock);
    rd(8'h13, 8'h2b);
    {irqOutN, resetOutN, sleepInputN, activeShutdownInput} <= 4'h5;
    sequencerMode <= SeqSleep;
    repeat (3) @(posedge clock);
    rd(8'h13, 8'h15);
    enableDrive <= 12'ha5c;
    enableSense <= 12'h3b6;
    repeat (3) @(posedge clock);
    rd(8'h14, 8'h0a);
    rd(8'h15, 8'h5c);
    rd(8'h16, 8'h03);
    rd(8'h17, 8'hb6);
    $display("pin state done");
    @(posedge clock);
    watchdogOpen <= 1'b1;
    watchdogEarlyEvent <= 1'b1;
    @(posedge clock);
    watchdogEarlyEvent <= 1'b0;
    rd(8'h18, 8'h0a);
    rd(8'h18, 8'h08);
    @(posedge clock);
    watchdogOpen <= 1'b0;
    watchdogExpiredEvent <= 1'b1;
    @(posedge clock);
    watchdogExpiredEvent <= 1'b0;
    rd(8'h18, 8'h01);
    rd(8'h18, 8'h00);
    @(posedge clock);
    selfTest <= 6'h2b;
    rd(8'h19, 8'h6a);
    $display("watchdog and self-test done");
    foreach (causeTable[i]) begin
      @(posedge clock);
      resetCause <= causeTable[i][16:8];
      resetEvent <= 1'b1;
      @(posedge clock);
      resetEvent <= 1'b0;
      rd(8'h1a, causeTable[i][7:0]);
    end
    host.writeReg(8'h1a, 8'hff);
    host.writeReg(8'h13, 8'hff);
    rd(8'h1a, 8'h0b);
    rd(8'h13, 8'h15);
    $display("reset cause and writes done");
    endSim();
  end
  // Whole sequence needs well under a thousand cycles
  initial begin
    #50000;
    failCount++;
    endSim();
  end
endmodule
`default_nettype wire
